// ### rtl/tmr_pkg.sv
package tmr_pkg;

    // Byte addresses on the core's data space
    localparam logic [7:0] ADDR_RB_LO = 8'hA7;
    localparam logic [7:0] ADDR_RB_HI = 8'hA8;
    localparam logic [7:0] ADDR_RA_LO = 8'hAA;
    localparam logic [7:0] ADDR_RA_HI = 8'hAB;
    localparam logic [7:0] ADDR_CNT_LO = 8'hAC;
    localparam logic [7:0] ADDR_CNT_HI = 8'hAD;
    localparam logic [7:0] ADDR_CTRL = 8'hAE;

    // Control register bit positions
    localparam int unsigned BIT_DUAL = 0;
    localparam int unsigned BIT_CAPTYPE = 1;
    localparam int unsigned BIT_IE = 2;
    localparam int unsigned BIT_PND = 3;
    localparam int unsigned BIT_RUN = 4;
    localparam int unsigned BIT_MLO = 5;
    localparam int unsigned BIT_MMID = 6;
    localparam int unsigned BIT_MHI = 7;

    // Reset and fixed values
    localparam logic [15:0] CNT_RST = 16'hFFFF;
    localparam logic [15:0] RELOAD_RST = 16'h0000;
    localparam logic [7:0] CTRL_RST = 8'h00;
    localparam logic [15:0] CNT_ZERO = 16'h0000;
    localparam logic [15:0] CNT_ONES = 16'hFFFF;
    localparam logic [15:0] CNT_STEP = 16'h0001;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    typedef enum logic [3:0] {
        MD_EVENT = 4'b0001,
        MD_PWM = 4'b0010,
        MD_CAP = 4'b0100,
        MD_DIFF = 4'b1000
    } tmr_mode_e;

    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [7:0] wdata;
    } tmr_bus_req_s;

    typedef struct packed {
        logic out;
        logic oe;
    } tmr_pin_s;

    typedef struct packed {
        logic [15:0] cnt;
        logic [15:0] ra;
        logic [15:0] rb;
        logic [7:0] ctrl;
        logic sel_b;
        logic tog;
        logic armed;
        logic pin_s1;
        logic pin_s2;
        logic pin_prev;
        logic [7:0] rdata;
        logic irq;
        tmr_pin_s pin;
    } tmr_state_s;

endpackage

// ### rtl/tmr_timer.sv
`timescale 1ns/10ps
`default_nettype none

module tmr_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rstn,
    // Core byte bus
    input wire tmr_pkg::tmr_bus_req_s bus_req,
    output logic [7:0] bus_rdata,
    // Core interrupt
    input wire logic global_ie,
    output logic timer_irq,
    // Shared port line
    input wire logic port_data,
    input wire logic port_dir,
    input wire logic timer_pin_in,
    output logic timer_pin_out,
    output logic timer_pin_oe
);

    localparam tmr_pkg::tmr_state_s ST_RST = '{
        cnt: tmr_pkg::CNT_RST,
        ra: tmr_pkg::RELOAD_RST,
        rb: tmr_pkg::RELOAD_RST,
        ctrl: tmr_pkg::CTRL_RST,
        rdata: tmr_pkg::BYTE_ZERO,
        default: '0
    };

    logic [1:0] rst_sync_q;
    logic rst_n;
    tmr_pkg::tmr_state_s s_q;
    tmr_pkg::tmr_state_s s_d;
    tmr_pkg::tmr_mode_e mode;
    logic cap_mode;
    logic running;
    logic rise;
    logic fall;
    logic tick;
    logic uf;
    logic set_pnd;
    logic set_uf;
    logic ed_start;
    logic ed_end;
    logic ctrl_wr;
    logic cnt_wr;
    logic [15:0] reload;

    // Asynchronous assert, release through two flops
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    always_comb begin
        s_d = s_q;
        ctrl_wr = bus_req.wr && (bus_req.addr == tmr_pkg::ADDR_CTRL);
        cnt_wr = bus_req.wr && ((bus_req.addr == tmr_pkg::ADDR_CNT_LO) ||
            (bus_req.addr == tmr_pkg::ADDR_CNT_HI));
        // Mode decode from the two high bits
        case ({s_q.ctrl[tmr_pkg::BIT_MHI], s_q.ctrl[tmr_pkg::BIT_MMID]})
            2'b00: begin
                mode = tmr_pkg::MD_EVENT;
            end
            2'b10: begin
                mode = tmr_pkg::MD_PWM;
            end
            2'b01: begin
                mode = tmr_pkg::MD_CAP;
            end
            default: begin
                mode = tmr_pkg::MD_DIFF;
            end
        endcase
        cap_mode = (mode == tmr_pkg::MD_CAP) || (mode == tmr_pkg::MD_DIFF);
        // Pin synchroniser and edge detect past the second flop
        s_d.pin_s1 = timer_pin_in;
        s_d.pin_s2 = s_q.pin_s1;
        s_d.pin_prev = s_q.pin_s2;
        rise = s_q.pin_s2 && !s_q.pin_prev;
        fall = !s_q.pin_s2 && s_q.pin_prev;
        // Bit 4 is a flag in capture modes, so those always count
        running = cap_mode || s_q.ctrl[tmr_pkg::BIT_RUN];
        if (mode == tmr_pkg::MD_EVENT) begin
            // Edges assumed at most half rate, else some are lost
            tick = running && (s_q.ctrl[tmr_pkg::BIT_MLO] ? fall : rise);
        end else begin
            tick = running;
        end
        uf = tick && (s_q.cnt == tmr_pkg::CNT_ZERO);
        if (cap_mode) begin
            reload = tmr_pkg::CNT_ONES;
        end else if (mode == tmr_pkg::MD_PWM && s_q.sel_b) begin
            reload = s_q.rb;
        end else begin
            reload = s_q.ra;
        end
        if (tick) begin
            s_d.cnt = uf ? reload : s_q.cnt - tmr_pkg::CNT_STEP;
        end
        // Alternate reload select, restarts on A
        if (mode != tmr_pkg::MD_PWM || !s_q.ctrl[tmr_pkg::BIT_RUN] ||
            !s_q.ctrl[tmr_pkg::BIT_DUAL]) begin
            s_d.sel_b = 1'b0;
        end else if (uf) begin
            s_d.sel_b = !s_q.sel_b;
        end
        // Toggle flop tracks the port level until toggling is on
        if (mode == tmr_pkg::MD_PWM && s_q.ctrl[tmr_pkg::BIT_MLO]) begin
            if (uf) begin
                s_d.tog = !s_q.tog;
            end
        end else begin
            s_d.tog = port_data;
        end
        // Software byte writes
        set_pnd = uf && !cap_mode;
        set_uf = uf && cap_mode;
        if (bus_req.wr) begin
            if (bus_req.addr == tmr_pkg::ADDR_RB_LO) begin
                s_d.rb[7:0] = bus_req.wdata;
            end else if (bus_req.addr == tmr_pkg::ADDR_RB_HI) begin
                s_d.rb[15:8] = bus_req.wdata;
            end else if (bus_req.addr == tmr_pkg::ADDR_RA_LO) begin
                s_d.ra[7:0] = bus_req.wdata;
            end else if (bus_req.addr == tmr_pkg::ADDR_RA_HI) begin
                s_d.ra[15:8] = bus_req.wdata;
            end else if (bus_req.addr == tmr_pkg::ADDR_CNT_LO) begin
                s_d.cnt[7:0] = bus_req.wdata;
            end else if (bus_req.addr == tmr_pkg::ADDR_CNT_HI) begin
                s_d.cnt[15:8] = bus_req.wdata;
            end
        end
        // Capture edges; hardware capture beats a same-cycle write
        ed_start = s_q.ctrl[tmr_pkg::BIT_MLO] ? fall : rise;
        if (s_q.ctrl[tmr_pkg::BIT_CAPTYPE]) begin
            ed_end = ed_start;
        end else begin
            ed_end = s_q.ctrl[tmr_pkg::BIT_MLO] ? rise : fall;
        end
        if (mode == tmr_pkg::MD_CAP && ed_start) begin
            s_d.ra = s_q.cnt;
            set_pnd = 1'b1;
        end
        if (mode != tmr_pkg::MD_DIFF) begin
            s_d.armed = 1'b0;
        end else if (s_q.armed && ed_end) begin
            // Counter ran down from all ones, so elapsed is its inverse
            s_d.ra = ~s_q.cnt;
            set_pnd = 1'b1;
            s_d.armed = s_q.ctrl[tmr_pkg::BIT_CAPTYPE];
            if (s_q.ctrl[tmr_pkg::BIT_CAPTYPE]) begin
                s_d.cnt = tmr_pkg::CNT_ONES;
            end
        end else if (!s_q.armed && ed_start) begin
            s_d.armed = 1'b1;
            s_d.cnt = tmr_pkg::CNT_ONES;
        end
        // Control write; flags only clear by 0, set wins
        if (ctrl_wr) begin
            s_d.ctrl = bus_req.wdata;
            s_d.ctrl[tmr_pkg::BIT_PND] = bus_req.wdata[tmr_pkg::BIT_PND] &&
                s_q.ctrl[tmr_pkg::BIT_PND];
            if (cap_mode) begin
                s_d.ctrl[tmr_pkg::BIT_RUN] = bus_req.wdata[tmr_pkg::BIT_RUN]
                    && s_q.ctrl[tmr_pkg::BIT_RUN];
            end
        end
        if (set_pnd) begin
            s_d.ctrl[tmr_pkg::BIT_PND] = 1'b1;
        end
        if (set_uf) begin
            s_d.ctrl[tmr_pkg::BIT_RUN] = 1'b1;
        end
        // Interrupt gated by local and global enables
        s_d.irq = s_q.ctrl[tmr_pkg::BIT_IE] && global_ie &&
            (s_q.ctrl[tmr_pkg::BIT_PND] ||
            (cap_mode && s_q.ctrl[tmr_pkg::BIT_RUN]));
        // Pin: in PWM, port_dir enables it and toggle PWM drives the timer level; input otherwise
        if (mode == tmr_pkg::MD_PWM) begin
            s_d.pin.out = s_q.ctrl[tmr_pkg::BIT_MLO] ? s_q.tog : port_data;
            s_d.pin.oe = port_dir;
        end else begin
            s_d.pin.out = port_data;
            s_d.pin.oe = 1'b0;
        end
        if (bus_req.rd) begin
            if (bus_req.addr == tmr_pkg::ADDR_RB_LO) begin
                s_d.rdata = s_q.rb[7:0];
            end else if (bus_req.addr == tmr_pkg::ADDR_RB_HI) begin
                s_d.rdata = s_q.rb[15:8];
            end else if (bus_req.addr == tmr_pkg::ADDR_RA_LO) begin
                s_d.rdata = s_q.ra[7:0];
            end else if (bus_req.addr == tmr_pkg::ADDR_RA_HI) begin
                s_d.rdata = s_q.ra[15:8];
            end else if (bus_req.addr == tmr_pkg::ADDR_CNT_LO) begin
                s_d.rdata = s_q.cnt[7:0];
            end else if (bus_req.addr == tmr_pkg::ADDR_CNT_HI) begin
                s_d.rdata = s_q.cnt[15:8];
            end else if (bus_req.addr == tmr_pkg::ADDR_CTRL) begin
                s_d.rdata = s_q.ctrl;
            end else begin
                s_d.rdata = tmr_pkg::BYTE_ZERO;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= ST_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign bus_rdata = s_q.rdata;
    assign timer_irq = s_q.irq;
    assign timer_pin_out = s_q.pin.out;
    assign timer_pin_oe = s_q.pin.oe;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    property p_stop;
        mode == tmr_pkg::MD_PWM && !s_q.ctrl[tmr_pkg::BIT_RUN] && !cnt_wr
            |=> s_q.cnt == $past(s_q.cnt);
    endproperty
    a_stop: assert property (p_stop)
        else $error("Stopped timer changed its count");

    property p_dec;
        mode == tmr_pkg::MD_PWM && s_q.ctrl[tmr_pkg::BIT_RUN] && !cnt_wr &&
            s_q.cnt != tmr_pkg::CNT_ZERO
            |=> s_q.cnt == $past(s_q.cnt) - tmr_pkg::CNT_STEP;
    endproperty
    a_dec: assert property (p_dec)
        else $error("Running counter did not decrement by one");

    property p_reload;
        mode == tmr_pkg::MD_PWM && uf && !s_q.sel_b && !cnt_wr
            |=> s_q.cnt == $past(s_q.ra) && s_q.ctrl[tmr_pkg::BIT_PND];
    endproperty
    a_reload: assert property (p_reload)
        else $error("Underflow did not reload from A and set pending");

    property p_dual;
        mode == tmr_pkg::MD_PWM && uf && s_q.ctrl[tmr_pkg::BIT_DUAL] &&
            !ctrl_wr |=> s_q.sel_b != $past(s_q.sel_b);
    endproperty
    a_dual: assert property (p_dual)
        else $error("Dual reload did not alternate");

    property p_toggle;
        mode == tmr_pkg::MD_PWM && s_q.ctrl[tmr_pkg::BIT_MLO] && uf &&
            !ctrl_wr |=> s_q.tog != $past(s_q.tog) ##1
            timer_pin_out == $past(s_q.tog);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("Pin did not toggle on underflow");

    property p_irq;
        timer_irq |-> $past(s_q.ctrl[tmr_pkg::BIT_IE]) && $past(global_ie);
    endproperty
    a_irq: assert property (p_irq)
        else $error("Interrupt raised while disabled");

    property p_hold;
        s_q.ctrl[tmr_pkg::BIT_PND] && !ctrl_wr
            |=> s_q.ctrl[tmr_pkg::BIT_PND];
    endproperty
    a_hold: assert property (p_hold)
        else $error("Pending flag dropped without a write");

    property p_noset;
        !s_q.ctrl[tmr_pkg::BIT_PND] && ctrl_wr && !set_pnd
            |=> !s_q.ctrl[tmr_pkg::BIT_PND];
    endproperty
    a_noset: assert property (p_noset)
        else $error("Software write set the pending flag");

    property p_event;
        mode == tmr_pkg::MD_EVENT && !rise && !fall && !cnt_wr
            |=> s_q.cnt == $past(s_q.cnt);
    endproperty
    a_event: assert property (p_event)
        else $error("Event counter moved without a pin edge");

    property p_cap;
        mode == tmr_pkg::MD_CAP && ed_start
            |=> s_q.ra == $past(s_q.cnt) && s_q.ctrl[tmr_pkg::BIT_PND];
    endproperty
    a_cap: assert property (p_cap)
        else $error("Capture edge did not latch the counter");

    c_pwm_uf: cover property (mode == tmr_pkg::MD_PWM && uf);
    c_evt_uf: cover property (mode == tmr_pkg::MD_EVENT && uf);
    c_cap: cover property (mode == tmr_pkg::MD_CAP && ed_start);
    c_diff: cover property (mode == tmr_pkg::MD_DIFF && s_q.armed && ed_end);

endmodule

`default_nettype wire

// ### verification/tmr_pin_partner.sv
`timescale 1ns/10ps
`default_nettype none

module tmr_pin_partner (
    // Clock
    input wire logic clk,
    // Level asked for by the bench
    input wire logic want_level,
    // Device side of the pin
    input wire logic pin_out,
    input wire logic pin_oe,
    output logic pin_level
);
    logic src_q = 1'b0;
    logic held_q = 1'b1;

    // A level must stand two full cycles before it may move again
    always @(posedge clk) begin
        held_q <= 1'b1;
        if (want_level != src_q && held_q) begin
            src_q <= want_level;
            held_q <= 1'b0;
        end
    end

    // Source backs off while the device drives the line
    assign pin_level = pin_oe ? pin_out : src_q;
endmodule

`default_nettype wire

// ### verification/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
    logic clk;
    logic rstn;
    tmr_pkg::tmr_bus_req_s bus_req;
    logic [7:0] bus_rdata;
    logic global_ie;
    logic timer_irq;
    logic port_data;
    logic port_dir;
    logic pin_level;
    logic want_level;
    logic timer_pin_out;
    logic timer_pin_oe;
    logic [7:0] exp_q[$];
    logic note;
    logic rd_seen = 1'b0;
    int mismatches = 0;
    int cmp_count = 0;
    int seed;
    logic [7:0] av[8] = '{8'hAC, 8'hAD, 8'hAA, 8'hAB, 8'hA7, 8'hA8, 8'hAE,
        8'hA9};
    logic [7:0] rv[8] = '{8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
        8'h00};
    logic [7:0] dc[4] = '{8'hC0, 8'hC2, 8'hE0, 8'hE2};
    logic [7:0] v[6];
    logic [15:0] a1;
    logic [15:0] a2;
    int n;

    tmr_timer uut (
        .clk(clk), .rstn(rstn), .bus_req(bus_req), .bus_rdata(bus_rdata),
        .global_ie(global_ie), .timer_irq(timer_irq),
        .port_data(port_data), .port_dir(port_dir),
        .timer_pin_in(pin_level), .timer_pin_out(timer_pin_out),
        .timer_pin_oe(timer_pin_oe)
    );

    tmr_pin_partner src (
        .clk(clk), .want_level(want_level), .pin_out(timer_pin_out),
        .pin_oe(timer_pin_oe), .pin_level(pin_level)
    );

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic tally_and_finish();
        $display("Comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic check_byte(string what, logic [7:0] e, logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic check_val(string what, logic [15:0] e, logic [15:0] g);
        cmp_count++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic wait_n(int k);
        repeat (k) @(posedge clk);
        #1;
    endtask

    // Strobe drops after one cycle, then one idle cycle so none is re-raised
    task automatic bus_op(logic w, logic [7:0] a, logic [7:0] d);
        bus_req.wr = w;
        bus_req.rd = !w;
        bus_req.addr = a;
        bus_req.wdata = d;
        wait_n(1);
        bus_req.wr = 1'b0;
        bus_req.rd = 1'b0;
        wait_n(1);
    endtask

    task automatic wr(logic [7:0] a, logic [7:0] d);
        bus_op(1'b1, a, d);
    endtask

    task automatic rd_exp(logic [7:0] a, logic [7:0] e);
        note = 1'b1;
        exp_q.push_back(e);
        bus_op(1'b0, a, 8'h00);
    endtask

    task automatic read16(output logic [15:0] r);
        note = 1'b0;
        bus_op(1'b0, 8'hAA, 8'h00);
        r[7:0] = bus_rdata;
        bus_op(1'b0, 8'hAB, 8'h00);
        r[15:8] = bus_rdata;
    endtask

    task automatic wait_toggle(output int c);
        logic p;
        p = timer_pin_out;
        c = 0;
        while (timer_pin_out === p && c < 200) begin
            wait_n(1);
            c++;
        end
        if (c >= 200) begin
            mismatches++;
            tally_and_finish();
        end
    endtask

    task automatic pulse(logic lvl);
        want_level = lvl;
        wait_n(8);
        want_level = !lvl;
        wait_n(8);
    endtask

    task automatic span(logic f, logic same, int w);
        want_level = f;
        if (same) begin
            wait_n(w / 2);
            want_level = !f;
            wait_n(w - w / 2);
            want_level = f;
        end else begin
            wait_n(w);
            want_level = !f;
        end
        wait_n(8);
        want_level = !f;
        wait_n(8);
    endtask

    // Read data shows the cycle after the strobe is taken
    always @(posedge clk) begin
        if (rd_seen) check_byte("read data", exp_q.pop_front(), bus_rdata);
        rd_seen <= bus_req.rd & note;
    end

    initial begin
        seed = 86404;
        bus_req = '0;
        note = 1'b0;
        rstn = 1'b0;
        global_ie = 1'b0;
        port_data = 1'b0;
        port_dir = 1'b0;
        want_level = 1'b0;
        wait_n(20);
        rstn = 1'b1;
        wait_n(3);
        for (int i = 0; i < 8; i++) rd_exp(av[i], rv[i]);
        for (int i = 0; i < 6; i++) begin
            v[i] = 8'($random(seed));
            wr(av[i], v[i]);
        end
        for (int i = 0; i < 6; i++) rd_exp(av[i], v[i]);
        wr(8'hAD, 8'h00);
        wr(8'hAC, 8'h40);
        wr(8'hAE, 8'h90);
        wait_n(8);
        wr(8'hAE, 8'h80);
        rd_exp(8'hAC, 8'h36);
        wait_n(5);
        rd_exp(8'hAC, 8'h36);
        wr(8'hAA, 8'h03);
        wr(8'hAB, 8'h00);
        wr(8'hA7, 8'h05);
        wr(8'hA8, 8'h00);
        wr(8'hAC, 8'h02);
        port_dir = 1'b1;
        global_ie = 1'b1;
        wr(8'hAE, 8'hB5);
        wait_toggle(n);
        check_val("pin enable", 16'h0001, {15'h0000, timer_pin_oe});
        wait_toggle(n);
        check_val("period after A", 16'h0004, 16'(n));
        wait_toggle(n);
        check_val("period after B", 16'h0006, 16'(n));
        wait_toggle(n);
        check_val("period after A", 16'h0004, 16'(n));
        wait_n(2);
        check_val("irq", 16'h0001, {15'h0000, timer_irq});
        wr(8'hAE, 8'hAD);
        rd_exp(8'hAE, 8'hAD);
        wr(8'hAE, 8'hA5);
        rd_exp(8'hAE, 8'hA5);
        check_val("irq", 16'h0000, {15'h0000, timer_irq});
        wr(8'hAE, 8'hAD);
        rd_exp(8'hAE, 8'hA5);
        port_dir = 1'b0;
        wr(8'hAC, 8'h01);
        wr(8'hAA, 8'h02);
        wr(8'hAE, 8'h14);
        pulse(1'b1);
        pulse(1'b1);
        rd_exp(8'hAC, 8'h02);
        rd_exp(8'hAE, 8'h1C);
        check_val("pin enable", 16'h0000, {15'h0000, timer_pin_oe});
        check_val("irq", 16'h0001, {15'h0000, timer_irq});
        global_ie = 1'b0;
        wait_n(2);
        check_val("irq", 16'h0000, {15'h0000, timer_irq});
        global_ie = 1'b1;
        wr(8'hAE, 8'h30);
        want_level = 1'b1;
        wait_n(8);
        rd_exp(8'hAC, 8'h02);
        want_level = 1'b0;
        wait_n(8);
        rd_exp(8'hAC, 8'h01);
        pulse(1'b1);
        pulse(1'b1);
        rd_exp(8'hAE, 8'h38);
        check_val("irq", 16'h0000, {15'h0000, timer_irq});
        wr(8'hAE, 8'h44);
        wait_n(6);
        rd_exp(8'hAE, 8'h54);
        check_val("irq", 16'h0001, {15'h0000, timer_irq});
        wr(8'hAE, 8'h44);
        rd_exp(8'hAE, 8'h44);
        for (int p = 0; p < 2; p++) begin
            want_level = p[0];
            wait_n(8);
            wr(8'hAE, p[0] ? 8'h64 : 8'h44);
            pulse(!p[0]);
            read16(a1);
            wait_n(24);
            pulse(!p[0]);
            read16(a2);
            check_val("capture spacing", 16'h002C, a1 - a2);
            rd_exp(8'hAE, p[0] ? 8'h6C : 8'h4C);
        end
        for (int m = 0; m < 4; m++) begin
            // Leave difference mode so a stale armed start is dropped
            wr(8'hAE, 8'h00);
            want_level = dc[m][5];
            wait_n(8);
            wr(8'hAE, dc[m]);
            span(!dc[m][5], dc[m][1], 20);
            read16(a1);
            span(!dc[m][5], dc[m][1], 30);
            read16(a2);
            check_val("interval growth", 16'h000A, a2 - a1);
            rd_exp(8'hAE, dc[m] | 8'h08);
        end
        wait_n(2);
        tally_and_finish();
    end
endmodule

`default_nettype wire
